// File: logic/tio_pkg.sv
// shared constants and state types for the timed port tile
package tio_pkg;
  // ==========================================================
  // sizes
  localparam int NPORT = 5;
  localparam int NCLK = 6;
  localparam int DW = 32;
  localparam int CW = 16;
  localparam int SCW = 6;
  localparam int DIVW = 8;
  localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};
  // ==========================================================
  // reference clock derivation: 100 MHz ticks out of 125 MHz
  localparam int REF_MHZ = 100;
  localparam int CLK_MHZ = 125;
  localparam int ACCW = 8;
  // ==========================================================
  // address map (byte addresses)
  localparam int AW = 12;
  localparam int PORT_LSB = 5;
  localparam int PORT_MSB = 7;
  localparam int REGION_LSB = 8;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DATA = 5'h04;
  localparam logic [4:0] REG_TIME = 5'h08;
  localparam logic [4:0] REG_STAMP = 5'h0C;
  localparam logic [4:0] REG_COND = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [3:0] REGION_PORT = 4'h0;
  localparam logic [3:0] REGION_CLK = 4'h1;
  localparam logic [AW-1:0] LINK_ADDR = 12'h1F0;
  // ==========================================================
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_OUT = 1;
  localparam int CTRL_OD = 2;
  localparam int CTRL_STB = 3;
  localparam int CTRL_COND = 4;
  localparam int CTRL_CLK = 8;
  localparam int CLK_EXT = 0;
  localparam int CLK_DIV = 8;
  localparam int ST_FULL = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_EVENT = 2;
  localparam int ST_ARMED = 3;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ} cond_t;

  typedef struct packed {
    logic en;
    logic dir_out;
    logic od;
    logic stb;
    cond_t cond;
    logic [2:0] clk_sel;
    logic [DW-1:0] xfer;
    logic full;
    logic [DW-1:0] shreg;
    logic busy;
    logic [SCW-1:0] scnt;
    logic [CW-1:0] cnt;
    logic [CW-1:0] stamp;
    logic [CW-1:0] tmatch;
    logic tarmed;
    logic [DW-1:0] cval;
    logic event_flag;
    logic ready_out;
  } port_state_t;

  typedef struct packed {
    logic ext;
    logic [DIVW-1:0] div;
    logic [DIVW-1:0] cnt;
  } clk_state_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [AW-1:0] addr;
  } bus_phase_t;

  typedef struct packed {
    port_state_t [NPORT-1:0] port;
    clk_state_t [NCLK-1:0] clk;
    logic [ACCW-1:0] ref_acc;
    logic [DW-1:0] link_mask;
    logic [DW-1:0] pin_out;
    logic [DW-1:0] pin_oe;
    logic [DW-1:0] pin_pd;
    logic ext_prev;
    bus_phase_t bus;
    logic [DW-1:0] hrdata;
    logic hready;
    logic hresp;
    logic [NPORT-1:0] wake;
    logic [NPORT-1:0] rdy;
  } tile_state_t;

  // pull-downs stay on everywhere until a port claims the pin
  localparam tile_state_t TILE_RESET = '{pin_pd: '1, hready: 1'b1, default: '0};
endpackage : tio_pkg

// File: logic/timed_port_tile.sv
// timed i/o port tile: five ports, six clock blocks, ahb-lite registers
// Behaviour
// - ports of 1, 4, 8, 16, 32 bits; one direction per port
// - ports drive pins or sample them, optionally waiting for a condition
// - each register access completes with zero wait states
// - open-drain: zero drives low, one releases; set per port
// - data passes through a serdes shift register plus a transfer register
// - a 16-bit port counter times transfers between pins and transfer register
// - counter readable anytime; a transfer can be scheduled at a counter value
// - the counter is captured as a timestamp on each transfer
// - an enabled link takes its pins away from every port
// - the narrowest enabled port owns shared pins; others keep unshared pins
// - a port always works at its nominal width
// - six clock blocks; block 0 is the 100 MHz reference clock
// - blocks 1 to 5 run at programmable rates
// - a block may take the 1-bit port pin as clock, optionally divided
// - ports accept an input-ready strobe and emit an output-ready strobe
// - after reset every port sits on clock block 0
// - pin conditions become events delivered to the cores
// - pull-downs are on for every pin during reset
`timescale 1ns/100ps
module timed_port_tile
  import tio_pkg::*;
(
  input wire logic hclk, // 125 MHz system clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic [DW-1:0] pin_in, // pin levels
  output logic [DW-1:0] pin_out, // pin drive level
  output logic [DW-1:0] pin_oe, // pin drive enable
  output logic [DW-1:0] pin_pulldown, // pull-down enable
  input wire logic [NPORT-1:0] input_ready_strobe, // per port ready from outside
  output logic [NPORT-1:0] output_ready_strobe, // per port data strobe
  output logic [NPORT-1:0] port_wake // per port sticky event to the cores
);

  // ==========================================================
  // state
  tile_state_t st;
  tile_state_t next_st;
  // unpacked so that each generate branch owns its own element as sole driver
  port_state_t next_port [NPORT];
  logic [NCLK-1:0] tick;
  logic ref_tick;
  logic ext_edge;
  logic addr_ok;
  logic wr_ok;
  logic [ACCW-1:0] acc_sum;

  // address phase taken only on a real transfer while the bus is ready
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_ok = st.bus.sel & st.bus.write;
  // rising edge of the 1-bit port pin, usable as an external clock
  assign ext_edge = pin_in[0] & ~st.ext_prev;

  // ==========================================================
  // clock blocks
  // reference clock block
  // fractional accumulator gives 100 ticks per 125 cycles; spacing jitters by one cycle
  assign acc_sum = st.ref_acc + ACCW'(REF_MHZ);
  assign ref_tick = acc_sum >= ACCW'(CLK_MHZ);
  assign tick[0] = ref_tick;

  genvar c;
  generate
    for (c = 1; c < NCLK; c++) begin : g_clk
      logic src;
      assign src = st.clk[c].ext ? ext_edge : ref_tick;
      assign tick[c] = src & (st.clk[c].cnt == st.clk[c].div);
    end
  endgenerate

  // ==========================================================
  // ports
  genvar k;
  generate
    for (k = 0; k < NPORT; k++) begin : g_port
      localparam int W = PORT_W[k];
      localparam int NS = DW / W;
      logic [W-1:0] pins_k;
      logic [DW-1:0] sh_in;
      logic tk;
      logic hit_w;
      logic hit_r;
      logic time_ok;
      logic cond_ok;
      logic gate;
      // samples always use the full nominal width
      assign pins_k = pin_in[W-1:0];
      if (W == DW) begin : g_full
        assign sh_in = pins_k;
      end else begin : g_part
        assign sh_in = {pins_k, st.port[k].shreg[DW-1:W]};
      end
      assign tk = (st.port[k].clk_sel < 3'(NCLK)) ? tick[st.port[k].clk_sel] : 1'b0;
      assign hit_w = wr_ok && st.bus.addr[AW-1:REGION_LSB] == REGION_PORT
        && st.bus.addr[PORT_MSB:PORT_LSB] == 3'(k);
      assign hit_r = addr_ok && !hwrite && haddr[AW-1:REGION_LSB] == REGION_PORT
        && haddr[PORT_MSB:PORT_LSB] == 3'(k) && haddr[PORT_LSB-1:0] == REG_DATA;
      assign time_ok = !st.port[k].tarmed || st.port[k].cnt == st.port[k].tmatch;
      assign gate = !st.port[k].stb || input_ready_strobe[k];

      // wait condition on the sampled pins
      always_comb begin
        case (st.port[k].cond)
          COND_EQ: cond_ok = pins_k == st.port[k].cval[W-1:0];
          COND_NEQ: cond_ok = pins_k != st.port[k].cval[W-1:0];
          default: cond_ok = 1'b1;
        endcase
      end

      // bus effects first, then the tick, so a hardware set beats a software clear
      always_comb begin
        next_port[k] = st.port[k];
        if (hit_w) begin
          case (st.bus.addr[PORT_LSB-1:0])
            REG_CTRL: begin
              next_port[k].en = hwdata[CTRL_EN];
              // one direction for the whole port
              next_port[k].dir_out = hwdata[CTRL_OUT];
              next_port[k].od = hwdata[CTRL_OD];
              next_port[k].stb = hwdata[CTRL_STB];
              next_port[k].cond = cond_t'(hwdata[CTRL_COND+:2]);
              next_port[k].clk_sel = hwdata[CTRL_CLK+:3];
            end
            REG_DATA: begin
              next_port[k].xfer = hwdata;
              next_port[k].full = 1'b1;
            end
            REG_TIME: begin
              next_port[k].tmatch = hwdata[CW-1:0];
              next_port[k].tarmed = 1'b1;
            end
            REG_COND: next_port[k].cval = hwdata;
            REG_STATUS: begin
              if (hwdata[ST_EVENT]) begin
                next_port[k].event_flag = 1'b0;
              end
            end
            default: ;
          endcase
        end
        // in input mode, reading the data empties the transfer register and clears the event
        if (hit_r && !st.port[k].dir_out) begin
          next_port[k].full = 1'b0;
          next_port[k].event_flag = 1'b0;
        end
        next_port[k].ready_out = 1'b0;
        if (tk && st.port[k].en) begin
          next_port[k].cnt = st.port[k].cnt + 16'h0001;
          if (st.port[k].dir_out) begin
            if (st.port[k].busy && st.port[k].scnt != '0) begin
              next_port[k].shreg = st.port[k].shreg >> W;
              next_port[k].scnt = st.port[k].scnt - 6'h01;
              next_port[k].ready_out = st.port[k].stb;
            end else if (next_port[k].full && time_ok) begin
              // timed load of the shift register
              next_port[k].shreg = next_port[k].xfer;
              next_port[k].full = 1'b0;
              next_port[k].busy = 1'b1;
              next_port[k].scnt = SCW'(NS - 1);
              next_port[k].stamp = st.port[k].cnt;
              next_port[k].tarmed = 1'b0;
              next_port[k].ready_out = st.port[k].stb;
            end else begin
              next_port[k].busy = 1'b0;
            end
          end else if (gate && (st.port[k].scnt != '0 || (time_ok && cond_ok))) begin
            next_port[k].shreg = sh_in;
            if (st.port[k].scnt == SCW'(NS - 1)) begin
              next_port[k].xfer = sh_in;
              next_port[k].full = 1'b1;
              next_port[k].event_flag = 1'b1;
              next_port[k].stamp = st.port[k].cnt;
              next_port[k].tarmed = 1'b0;
              next_port[k].scnt = '0;
            end else begin
              next_port[k].scnt = st.port[k].scnt + 6'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    logic [DW-1:0] rd;
    logic owned;
    logic bit_v;
    int p_k;
    rd = '0;
    owned = 1'b0;
    bit_v = 1'b0;
    p_k = 0;
    next_st = st;
    for (int i = 0; i < NPORT; i++) begin
      next_st.port[i] = next_port[i];
    end
    next_st.ext_prev = pin_in[0];
    next_st.ref_acc = ref_tick ? acc_sum - ACCW'(CLK_MHZ) : acc_sum;
    // divider counters on blocks 1 to 5
    for (int i = 1; i < NCLK; i++) begin
      if (st.clk[i].ext ? ext_edge : ref_tick) begin
        next_st.clk[i].cnt = tick[i] ? '0 : st.clk[i].cnt + 8'h01;
      end
    end
    // register writes outside the port regions
    if (wr_ok && st.bus.addr == LINK_ADDR) begin
      next_st.link_mask = hwdata;
    end
    if (wr_ok && st.bus.addr[AW-1:REGION_LSB] == REGION_CLK) begin
      for (int i = 1; i < NCLK; i++) begin
        if (st.bus.addr[REGION_LSB-1:2] == 6'(i)) begin
          next_st.clk[i].ext = hwdata[CLK_EXT];
          next_st.clk[i].div = hwdata[CLK_DIV+:DIVW];
          next_st.clk[i].cnt = '0;
        end
      end
    end
    // single-cycle answer, read data registered at the address phase
    next_st.hready = 1'b1;
    next_st.hresp = 1'b0;
    next_st.bus.sel = addr_ok;
    next_st.bus.write = hwrite;
    next_st.bus.addr = haddr[AW-1:0];
    if (addr_ok && !hwrite) begin
      if (haddr[AW-1:0] == LINK_ADDR) begin
        rd = st.link_mask;
      end else if (haddr[AW-1:REGION_LSB] == REGION_CLK) begin
        for (int i = 0; i < NCLK; i++) begin
          if (haddr[REGION_LSB-1:2] == 6'(i)) begin
            rd[CLK_EXT] = st.clk[i].ext;
            rd[CLK_DIV+:DIVW] = st.clk[i].div;
          end
        end
      end else if (haddr[AW-1:REGION_LSB] == REGION_PORT) begin
        for (int i = 0; i < NPORT; i++) begin
          if (haddr[PORT_MSB:PORT_LSB] == 3'(i)) begin
            case (haddr[PORT_LSB-1:0])
              REG_CTRL: begin
                rd[CTRL_EN] = st.port[i].en;
                rd[CTRL_OUT] = st.port[i].dir_out;
                rd[CTRL_OD] = st.port[i].od;
                rd[CTRL_STB] = st.port[i].stb;
                rd[CTRL_COND+:2] = st.port[i].cond;
                rd[CTRL_CLK+:3] = st.port[i].clk_sel;
              end
              REG_DATA: rd = st.port[i].xfer;
              REG_TIME: rd[CW-1:0] = st.port[i].cnt;
              REG_STAMP: rd[CW-1:0] = st.port[i].stamp;
              REG_COND: rd = st.port[i].cval;
              REG_STATUS: begin
                rd[ST_FULL] = st.port[i].full;
                rd[ST_BUSY] = st.port[i].busy;
                rd[ST_EVENT] = st.port[i].event_flag;
                rd[ST_ARMED] = st.port[i].tarmed;
              end
              default: ;
            endcase
          end
        end
      end
    end
    next_st.hrdata = (addr_ok && !hwrite) ? rd : st.hrdata;
    // pin ownership: lowest index (narrowest) enabled port wins
    for (int p = 0; p < DW; p++) begin
      owned = 1'b0;
      p_k = 0;
      for (int j = NPORT - 1; j >= 0; j--) begin
        if (next_port[j].en && p < PORT_W[j]) begin
          owned = 1'b1;
          p_k = j;
        end
      end
      if (next_st.link_mask[p]) begin
        owned = 1'b0;
      end
      bit_v = next_port[p_k].shreg[p];
      next_st.pin_pd[p] = !owned;
      next_st.pin_out[p] = 1'b0;
      next_st.pin_oe[p] = 1'b0;
      if (owned && next_port[p_k].dir_out) begin
        next_st.pin_out[p] = next_port[p_k].od ? 1'b0 : bit_v;
        next_st.pin_oe[p] = next_port[p_k].od ? !bit_v : 1'b1;
      end
    end
    for (int i = 0; i < NPORT; i++) begin
      next_st.wake[i] = next_port[i].event_flag;
      next_st.rdy[i] = next_port[i].ready_out;
    end
  end

  // ==========================================================
  // single state register
  // reset value: clock block 0, pull-downs on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= TILE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign hrdata = st.hrdata;
  assign hreadyout = st.hready;
  assign hresp = st.hresp;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign pin_pulldown = st.pin_pd;
  assign output_ready_strobe = st.rdy;
  assign port_wake = st.wake;

endmodule : timed_port_tile

// File: bench/tio_checker_assertions.sv
// concurrent checks on the timed port tile ports
`timescale 1ns/100ps
module tio_checker
  import tio_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic hready, // bus ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [DW-1:0] pin_out, // pin level
  input wire logic [DW-1:0] pin_oe, // pin enable
  input wire logic [DW-1:0] pin_pulldown, // pull-downs
  input wire logic [NPORT-1:0] output_ready_strobe, // out strobes
  input wire logic [NPORT-1:0] port_wake // wake flags
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // bus transfers
  sequence s_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_read;
    s_taken ##0 !hwrite;
  endsequence
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  // read data may only move on a taken read
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  // ==========================================================
  // pins and events
  a_reset_state: assert property ($rose(hresetn) |-> pin_pulldown == '1 && pin_oe == '0 && port_wake == '0)
    else $error("pins not idle after reset");
  a_drive_no_pd: assert property ((pin_oe & pin_pulldown) == '0)
    else $error("pull-down on a driven pin");
  // an open-drain slice of all ones drives nothing, but its pins stay claimed (pull-downs off)
  a_strobe_drive: assert property (output_ready_strobe != '0 |-> (pin_oe | ~pin_pulldown) != '0)
    else $error("strobe without driven data");
  // a wake flag is sticky: it drops only shortly after a bus access
  a_wake_sticky: assert property ((|($past(port_wake) & ~port_wake)) |->
    $past(hsel && htrans[1] && hready, 1) || $past(hsel && htrans[1] && hready, 2) ||
    $past(hsel && htrans[1] && hready, 3) || $past(hsel && htrans[1] && hready, 4))
    else $error("wake dropped without access");
  // a frozen tile must not move its pins or its wake flags
  a_ce_freeze: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(port_wake))
    else $error("state moved while frozen");
  c_read: cover property (s_read);
endmodule : tio_checker

// File: bench/pin_model.sv
// outside hardware on the tile pins: data driver and ready strobe
`timescale 1ns/100ps
module pin_model (
  input wire logic clk, // bench clock
  input wire logic [31:0] pin_out, // device level
  input wire logic [31:0] pin_oe, // device enable
  input wire logic [31:0] pin_pulldown, // device pull-downs
  input wire logic [31:0] drive_en, // outside drive enable
  input wire logic [31:0] drive_val, // outside level
  input wire logic ready_in, // outside ready level
  output logic [31:0] pin_in, // resolved levels
  output logic [4:0] input_ready_strobe // ready to every port
);
  logic [31:0] last;
  // released pins float unless driven from outside or pulled down
  // a floating pin shows the inverse of its last level so no stale value passes
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_val) | (~pin_oe & ~drive_en & ~pin_pulldown & ~last);
  always_ff @(posedge clk) last <= pin_in;
  assign input_ready_strobe = {5{ready_in}};
endmodule : pin_model

// File: bench/test_timed_port_tile.sv
// self-checking bench for the timed port tile
`timescale 1ns/100ps
module test_timed_port_tile;
  import tio_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, ready_in = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, drive_en = '0, drive_val = '0;
  logic [31:0] hrdata, pin_in, pin_out, pin_oe, pin_pulldown, rd, r0, d, seed = 32'h4DDA;
  logic [1:0] htrans = 2'h0;
  logic [3:0] v;
  logic hreadyout, hresp;
  logic [4:0] irs, ors, wake;
  int mismatches = 0, check_count = 0, n;
  timed_port_tile u_dut(.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown),
    .input_ready_strobe(irs), .output_ready_strobe(ors), .port_wake(wake));
  pin_model u_pins(.clk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown),
    .drive_en(drive_en), .drive_val(drive_val), .ready_in(ready_in), .pin_in(pin_in), .input_ready_strobe(irs));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // lsb byte goes out first
  function automatic logic [31:0] slice(input logic [31:0] w, input int i);
    return (w >> (8 * i)) & 32'h000000FF;
  endfunction : slice
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one ahb-lite single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ_BIT;
    // ready is read before the edge's updates land, so as sampled; only the watchdog ends a wait
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, dummy);
  endtask : wr
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // clock, reset, watchdog
  initial forever #4 hclk = ~hclk;
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
  end
  // the tests need under a thousand cycles; this is over twenty times that
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge hclk);
    chk(pin_pulldown, '1);
    for (int k = 0; k < NPORT; k++) begin
      bus(1'b0, 12'(k * 32), '0, rd);
      chk(rd, '0);
    end
    bus(1'b0, 12'h0C0, '0, rd);
    chk(rd, '0);
    bus(1'b0, 12'h100, '0, r0);
    wr(12'h100, 32'h0000FF01);
    bus(1'b0, 12'h100, '0, rd);
    chk(rd, '0);
    for (int i = 1; i < NCLK; i++) begin
      d = xs() & 32'h0000FF00;
      wr(12'(256 + 4 * i), d);
      bus(1'b0, 12'(256 + 4 * i), '0, rd);
      chk(rd, d);
    end
    note("registers");
    // counter on block 0 runs at 100 of every 125 cycles, 22 cycles apart
    wr(12'h040, 32'h00000001);
    bus(1'b0, 12'h048, '0, r0);
    repeat (20) @(posedge hclk);
    bus(1'b0, 12'h048, '0, rd);
    chk(32'(16'(rd - r0) inside {[16'd17:16'd18]}), 32'h1);
    // a word finished in input mode is emptied by the data read, so only the new word goes out once the port turns round
    wr(12'h040, '0);
    bus(1'b0, 12'h044, '0, rd);
    d = xs();
    wr(12'h040, 32'h0000000B);
    wr(12'h044, d);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      for (n = 0; n < 50 && ors[2] !== 1'b1; n++) @(posedge hclk);
      chk({23'h0, ors[2], pin_out[7:0]}, 32'h00000100 | slice(d, i));
    end
    // scheduled load 40 counts ahead; the stamp must equal the scheduled count
    bus(1'b0, 12'h048, '0, r0);
    r0 = 32'(16'(r0 + 32'h00000028));
    wr(12'h048, r0);
    wr(12'h044, d);
    repeat (80) @(posedge hclk);
    bus(1'b0, 12'h04C, '0, rd);
    chk(rd, r0);
    // the 1-bit port takes pin 0 from the 8-bit port
    wr(12'h000, 32'h00000007);
    wr(12'h004, 32'h00000000);
    repeat (60) @(posedge hclk);
    chk(32'({pin_oe[7:0], pin_out[0]}), 32'h000001FE);
    wr(12'h004, 32'hFFFFFFFF);
    repeat (100) @(posedge hclk);
    chk(32'(pin_oe[0]), 32'h0);
    wr(12'h1F0, 32'h000000FF);
    repeat (3) @(posedge hclk);
    chk(32'(pin_oe[7:0]), 32'h0);
    wr(12'h1F0, '0);
    wr(12'h000, '0);
    wr(12'h040, '0);
    note("output");
    v = 4'(xs());
    drive_en <= 32'h0000000F;
    drive_val <= {8{v}};
    wr(12'h030, {28'h0, v});
    wr(12'h020, 32'h00000019);
    repeat (60) @(posedge hclk);
    chk(32'(wake[1]), 32'h0);
    ready_in <= 1'b1;
    for (n = 0; n < 100 && wake[1] !== 1'b1; n++) @(posedge hclk);
    chk(32'(wake[1]), 32'h1);
    bus(1'b0, 12'h024, '0, rd);
    chk(rd, {8{v}});
    repeat (3) @(posedge hclk);
    chk(32'(wake[1]), 32'h0);
    note("input");
    // a frozen tile keeps its counter: only the two edges around the first read may tick
    bus(1'b0, 12'h028, '0, r0);
    ce <= 1'b0;
    repeat (40) @(posedge hclk);
    ce <= 1'b1;
    bus(1'b0, 12'h028, '0, rd);
    chk(32'(16'(rd - r0) inside {[16'd1:16'd2]}), 32'h1);
    note("freeze");
    wrap_up();
  end
endmodule : test_timed_port_tile

bind timed_port_tile tio_checker u_chk(.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_pulldown(pin_pulldown), .output_ready_strobe(output_ready_strobe), .port_wake(port_wake));
